// ==== rtl/spi_master_pkg.sv ====
// Shared constants of the serial peripheral port, master side.
// Assumes a single 200 MHz system clock and a synchronous active-high reset.
package spi_master_pkg;

  // ************************************************************
  // Widths and timing
  // ************************************************************
  localparam int unsigned BYTE_W         = 8;      // Width of one serial word.
  localparam int unsigned RATE_W         = 8;      // Width of the clock rate divisor.
  localparam int unsigned HALF_W         = 9;      // Width of a half-period count.
  localparam int unsigned EDGE_W         = 4;      // Width of the serial clock edge count.
  localparam int unsigned SYS_PERIOD_NS  = 5;      // System clock period in ns.
  localparam int unsigned MAX_RATE_KHZ   = 12500;  // Fastest allowed master bit rate.
  // Shortest half period of the serial clock, in ns, at the fastest rate.
  localparam int unsigned MIN_HALF_NS    = 1000000 / (2 * MAX_RATE_KHZ);
  // A least time rounds up to whole system clock cycles.
  localparam int unsigned MIN_HALF_CYC   = (MIN_HALF_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [HALF_W-1:0] MIN_HALF = HALF_W'(MIN_HALF_CYC);
  localparam logic [EDGE_W-1:0] EDGE_LAST = 4'hF;  // Sixteen edges make eight clocks.

  // ************************************************************
  // Control register field positions
  // ************************************************************
  localparam int unsigned CTL_DONE_POS   = 7;  // Transfer done flag.
  localparam int unsigned CTL_WRITE_COLLISION_FLAG_POS   = 6;  // Write collision flag.
  localparam int unsigned CTL_MODE_FAULT_FLAG_POS   = 5;  // Mode fault flag.
  localparam int unsigned CTL_OVRN_POS   = 4;  // Receive overrun flag.
  localparam int unsigned CTL_SELU_POS   = 3;  // Select mode upper bit.
  localparam int unsigned CTL_SELL_POS   = 2;  // Select mode lower bit.
  localparam int unsigned CTL_TXE_POS    = 1;  // Transmit buffer empty, read only.
  localparam int unsigned CTL_PEN_POS    = 0;  // Port enable bit.

  // ************************************************************
  // Configuration register field positions
  // ************************************************************
  localparam int unsigned CFG_MEN_POS    = 6;  // Master enable flag.
  localparam int unsigned CFG_PHA_POS    = 5;  // Clock phase bit.
  localparam int unsigned CFG_POL_POS    = 4;  // Clock polarity bit.

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic RST_SELU = 1'b0;  // Multi-master mode is the default.
  localparam logic RST_SELL = 1'b1;
  localparam logic [BYTE_W-1:0] RST_BYTE = 8'h00;

  // Transfer engine states.
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_FINISH} eng_state_t;

endpackage

// ==== rtl/sck_timer.sv ====
// Half-period tick generator for the serial clock.
// Assumes the caller holds run high for the length of a transfer.
module sck_timer
  import spi_master_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              run,
  input  wire logic [HALF_W-1:0] half_len,
  output logic                   tick
);

  // ************************************************************
  // Counter
  // ************************************************************
  logic [HALF_W-1:0] cnt_q;  // Cycles elapsed in this half period.
  logic [HALF_W-1:0] cnt_d;  // Next count.
  wire               wrap = (cnt_q == half_len - HALF_W'(1));  // Half period complete.

  assign tick  = run && wrap;
  assign cnt_d = (!run || wrap) ? '0 : cnt_q + HALF_W'(1);

  // The count restarts whenever the engine is not shifting, so each
  // transfer gets a full half period of setup before its first edge.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

// ==== rtl/rx_buffer.sv ====
// Two-entry receive buffer with valid and ready on both sides.
// Assumes the reader may stall; the head entry is presented from a register.
module rx_buffer #(
  parameter int unsigned W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [W-1:0] tail_q;  // Second entry, waiting behind the head.
  logic         tail_v_q;  // Second entry is occupied.
  wire          push = in_valid && in_ready;  // Word accepted.
  wire          pop  = out_valid && out_ready;  // Word delivered.

  // Full means both entries hold a word; the writer then stalls.
  assign in_ready = !tail_v_q;

  // Head register drives the reader directly, tail refills it on a pop.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_valid <= 1'b0;
      tail_v_q  <= 1'b0;
      out_data  <= '0;
      tail_q    <= '0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          if (!out_valid) begin
            out_data  <= in_data;
            out_valid <= 1'b1;
          end else begin
            tail_q   <= in_data;
            tail_v_q <= 1'b1;
          end
        end
        2'b01: begin
          out_data  <= tail_q;
          out_valid <= tail_v_q;
          tail_v_q  <= 1'b0;
        end
        2'b11: begin
          if (tail_v_q) begin
            out_data <= tail_q;
            tail_q   <= in_data;
          end else begin
            out_data <= in_data;
          end
        end
        default: begin
          out_valid <= out_valid;
        end
      endcase
    end
  end

endmodule

// ==== rtl/spi_master.sv ====
// Serial peripheral port, master side, with three slave select modes.
// Assumes all inputs are synchronous to sys_clk and the processor side
// writes its control and configuration bytes through one-cycle strobes.

// Contract
// R01: Transfers run only while master enable set.
// R02: Data write loads buffer; empty shifter starts; here start also waits for room in the receive buffer.
// R03: Started transfer drives clock and data alone.
// R04: Done flag and interrupt at transfer end.
// R05: Receive during transmit; done means both.
// R06: Received bits MSB first into receive buffer.
// R07: Multi-master default; select line is input.
// R08: Select low faults: disable, set mode fault.
// R09: Software re-enables both bits after fault.
// R10: Both select bits zero: select line unused.
// R11: Upper select bit set: select is output.
// R12: Select output follows lower select bit.
// R13: Bit counter resets only via port enable; here clearing master enable also resets it.
// R14: Three-wire slave must be alone on bus.
// R15: Write while buffer full ignored, collision set.
// R16: Software alone clears the status flags.
// R17: Phase picks latch edge, polarity idle level.
// R18: Bit rate at most 12.5 MHz.
// R19: Exactly eight clocks, then idle level.
module spi_master
  import spi_master_pkg::*;
(
  input  wire logic                            sys_clk,
  input  wire logic                            rst,
  input  wire logic                            ctrl_wr,
  input  wire logic [spi_master_pkg::BYTE_W-1:0] ctrl_wdata,
  input  wire logic                            cfg_wr,
  input  wire logic [spi_master_pkg::BYTE_W-1:0] cfg_wdata,
  input  wire logic [spi_master_pkg::RATE_W-1:0] rate_div,
  input  wire logic                            int_enable,
  input  wire logic                            tx_wr,
  input  wire logic [spi_master_pkg::BYTE_W-1:0] tx_byte,
  output logic                                 rx_valid,
  input  wire logic                            rx_ready,
  output logic [spi_master_pkg::BYTE_W-1:0]    rx_byte,
  output logic [spi_master_pkg::BYTE_W-1:0]    ctrl_rdata,
  output logic [spi_master_pkg::BYTE_W-1:0]    cfg_rdata,
  output logic                                 int_request,
  output logic                                 sck,
  output logic                                 mosi,
  input  wire logic                            miso,
  input  wire logic                            slave_select_line_i,
  output logic                                 slave_select_line_o,
  output logic                                 slave_select_line_oe
);
  import spi_master_pkg::*;

  // ************************************************************
  // Control state
  // ************************************************************
  logic              master_enable_flag_q;   // Master enable flag.
  logic              port_enable_bit_q;      // Port enable bit.
  logic              select_mode_upper_bit_q;  // Select mode upper bit.
  logic              select_mode_lower_bit_q;  // Select mode lower bit.
  logic              clock_phase_bit_q;      // Latch on trailing edge when set.
  logic              clock_polarity_bit_q;   // Idle level of the serial clock.
  logic              transfer_done_flag_q;   // Sticky end-of-byte flag.
  logic              write_collision_flag_q; // Sticky rejected-write flag.
  logic              mode_fault_flag_q;      // Sticky mode fault flag.
  logic [BYTE_W-1:0] tx_buf_q;               // Transmit buffer.
  logic              tx_full_q;              // Transmit buffer holds a byte.
  eng_state_t        state_q;                // Transfer engine state.
  logic [EDGE_W-1:0] edge_cnt_q;             // Serial clock edges so far.
  logic [BYTE_W-1:0] shift_q;                // Shift register, out and in.

  // ************************************************************
  // Decodes
  // ************************************************************
  wire mm_mode     = !select_mode_upper_bit_q && select_mode_lower_bit_q;  // see R07
  wire three_wire  = !select_mode_upper_bit_q && !select_mode_lower_bit_q;  // see R10
  wire active      = master_enable_flag_q && port_enable_bit_q;  // see R01
  // A low select input while mastering in multi-master mode is a fault.
  wire fault_now   = active && mm_mode && !slave_select_line_i;  // see R08
  wire rx_in_ready;  // Receive buffer can take a byte.
  wire tick;         // Half period of the serial clock elapsed.
  // Start waits for room in the receive buffer, so no byte is ever dropped.
  wire start       = (state_q == ST_IDLE) && tx_full_q && active && !fault_now
                     && rx_in_ready;  // see R02
  wire tx_accept   = tx_wr && !tx_full_q;  // see R02
  wire tx_collide  = tx_wr && tx_full_q;  // see R15
  wire leading     = !edge_cnt_q[0];  // Even count means the next edge leads.
  wire sample_now  = tick && (clock_phase_bit_q ? !leading : leading);  // see R17
  wire drive_now   = tick && (clock_phase_bit_q ? leading : !leading);  // see R17
  wire abort       = fault_now || !active;
  wire rx_push     = (state_q == ST_FINISH);  // see R05
  wire clr_done    = ctrl_wr && !ctrl_wdata[CTL_DONE_POS];
  wire clr_write_collision_flag    = ctrl_wr && !ctrl_wdata[CTL_WRITE_COLLISION_FLAG_POS];
  wire clr_mode_fault_flag    = ctrl_wr && !ctrl_wdata[CTL_MODE_FAULT_FLAG_POS];
  wire [HALF_W-1:0] req_half = HALF_W'(rate_div) + HALF_W'(1);
  // The divisor can ask for a faster clock than allowed, so it is clamped.
  wire [HALF_W-1:0] half_len = (req_half < MIN_HALF) ? MIN_HALF : req_half;  // see R18

  // ************************************************************
  // Helpers
  // ************************************************************
  // Paces the serial clock edges while a byte is shifting.
  sck_timer u_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .run      (state_q == ST_SHIFT),
    .half_len (half_len),
    .tick     (tick)
  );

  // Holds received bytes until the processor takes them.
  rx_buffer #(.W(BYTE_W)) u_rxbuf (
    .sys_clk   (sys_clk),
    .rst       (rst),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (shift_q),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_data  (rx_byte)
  );

  // ************************************************************
  // Control and flags
  // ************************************************************
  // A fault overrides a software write of either enable bit in the same cycle, and every
  // flag set wins over a clear that arrives with it.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      master_enable_flag_q    <= 1'b0;
      port_enable_bit_q       <= 1'b0;
      select_mode_upper_bit_q <= RST_SELU;
      select_mode_lower_bit_q <= RST_SELL;
      clock_phase_bit_q       <= 1'b0;
      clock_polarity_bit_q    <= 1'b0;
      transfer_done_flag_q    <= 1'b0;
      write_collision_flag_q  <= 1'b0;
      mode_fault_flag_q       <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        select_mode_upper_bit_q <= ctrl_wdata[CTL_SELU_POS];
        select_mode_lower_bit_q <= ctrl_wdata[CTL_SELL_POS];
        port_enable_bit_q       <= ctrl_wdata[CTL_PEN_POS];
      end
      if (cfg_wr) begin
        master_enable_flag_q <= cfg_wdata[CFG_MEN_POS];
        clock_phase_bit_q    <= cfg_wdata[CFG_PHA_POS];
        clock_polarity_bit_q <= cfg_wdata[CFG_POL_POS];
      end
      if (fault_now) begin
        master_enable_flag_q <= 1'b0;  // see R08
        port_enable_bit_q    <= 1'b0;  // see R08
      end
      transfer_done_flag_q   <= rx_push || (transfer_done_flag_q && !clr_done);  // see R04
      write_collision_flag_q <= tx_collide || (write_collision_flag_q && !clr_write_collision_flag);  // see R15
      mode_fault_flag_q      <= fault_now || (mode_fault_flag_q && !clr_mode_fault_flag);  // see R08
    end
  end

  // ************************************************************
  // Transmit buffer
  // ************************************************************
  // A write into a full buffer leaves the held byte untouched.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_buf_q  <= RST_BYTE;
      tx_full_q <= 1'b0;
    end else begin
      if (tx_accept) begin
        tx_buf_q  <= tx_byte;  // see R02
        tx_full_q <= 1'b1;
      end else if (start) begin
        tx_full_q <= 1'b0;  // see R02
      end
    end
  end

  // ************************************************************
  // Transfer engine
  // ************************************************************
  // Sixteen edges per byte; the clock ends at its idle level by parity.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q    <= ST_IDLE;
      edge_cnt_q <= '0;
      shift_q    <= RST_BYTE;
      sck        <= 1'b0;
      mosi       <= 1'b0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sck        <= clock_polarity_bit_q;  // see R19
          edge_cnt_q <= '0;  // see R13
          if (start) begin
            shift_q <= tx_buf_q;
            state_q <= ST_SHIFT;  // see R03
            if (!clock_phase_bit_q) begin
              mosi <= tx_buf_q[BYTE_W-1];
            end
          end
        end
        ST_SHIFT: begin
          if (abort) begin
            state_q    <= ST_IDLE;
            edge_cnt_q <= '0;  // see R13
          end else if (tick) begin
            sck        <= !sck;  // see R03
            edge_cnt_q <= edge_cnt_q + EDGE_W'(1);
            if (sample_now) begin
              shift_q <= {shift_q[BYTE_W-2:0], miso};  // see R06
            end
            if (drive_now) begin
              mosi <= shift_q[BYTE_W-1];
            end
            if (edge_cnt_q == EDGE_LAST) begin
              state_q <= ST_FINISH;  // see R19
            end
          end
        end
        ST_FINISH: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Slave select pin and status images
  // ************************************************************
  // The pin is only driven in four-wire mode; the receive overrun bit
  // reads zero because a master never overruns.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slave_select_line_oe <= 1'b0;
      slave_select_line_o  <= 1'b1;
      ctrl_rdata           <= '0;
      cfg_rdata            <= '0;
      int_request          <= 1'b0;
    end else begin
      slave_select_line_oe <= select_mode_upper_bit_q;  // see R11
      slave_select_line_o  <= select_mode_lower_bit_q;  // see R12
      ctrl_rdata                <= '0;
      ctrl_rdata[CTL_DONE_POS]  <= transfer_done_flag_q;
      ctrl_rdata[CTL_WRITE_COLLISION_FLAG_POS]  <= write_collision_flag_q;
      ctrl_rdata[CTL_MODE_FAULT_FLAG_POS]  <= mode_fault_flag_q;
      ctrl_rdata[CTL_SELU_POS]  <= select_mode_upper_bit_q;
      ctrl_rdata[CTL_SELL_POS]  <= select_mode_lower_bit_q;
      ctrl_rdata[CTL_TXE_POS]   <= !tx_full_q;
      ctrl_rdata[CTL_PEN_POS]   <= port_enable_bit_q;
      cfg_rdata                 <= '0;
      cfg_rdata[CFG_MEN_POS]    <= master_enable_flag_q;
      cfg_rdata[CFG_PHA_POS]    <= clock_phase_bit_q;
      cfg_rdata[CFG_POL_POS]    <= clock_polarity_bit_q;
      int_request <= int_enable && (transfer_done_flag_q || write_collision_flag_q
                                    || mode_fault_flag_q);  // see R04
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_start;
    start;
  endsequence

  sequence s_loaded;
    (state_q == ST_SHIFT) && (shift_q == $past(tx_buf_q));
  endsequence

  start_load_a: assert property (s_start |=> s_loaded)  // see R02
    else $error("transfer did not load the buffered byte");
  done_set_a: assert property (rx_push |=> transfer_done_flag_q)  // see R04
    else $error("done flag not set after byte");
  eight_clocks_a: assert property (rx_push |-> $past(edge_cnt_q) == EDGE_LAST)  // see R19
    else $error("byte finished without sixteen edges");
  fault_disable_a: assert property (fault_now |=>  // see R08
      !master_enable_flag_q && !port_enable_bit_q && mode_fault_flag_q)
    else $error("mode fault did not disable the port");
  collision_keep_a: assert property (tx_collide |=>  // see R15
      write_collision_flag_q && tx_buf_q == $past(tx_buf_q))
    else $error("colliding write changed the buffer");
  select_out_a: assert property (select_mode_upper_bit_q |=>  // see R12
      slave_select_line_oe && slave_select_line_o == $past(select_mode_lower_bit_q))
    else $error("select output does not follow lower bit");
  select_input_a: assert property (!select_mode_upper_bit_q |=> !slave_select_line_oe)  // see R07
    else $error("select pin driven outside four-wire mode");
  sck_idle_a: assert property ((state_q == ST_IDLE) && $past(state_q == ST_IDLE)  // see R19
      |-> sck == $past(clock_polarity_bit_q))
    else $error("serial clock not at idle level");
  rate_limit_a: assert property ($changed(sck) && state_q == ST_SHIFT  // see R18
      |=> (!$changed(sck) || state_q != ST_SHIFT) [*7])
    else $error("serial clock half period too short");
  inactive_a: assert property (!active |=> state_q != ST_SHIFT)  // see R01
    else $error("engine shifting without master enable");
  // Three-wire mode leaves the select pin undriven, so it may go elsewhere.
  unused_select_a: assert property (three_wire |=> !slave_select_line_oe)  // see R10
    else $error("select pin driven in three-wire mode");

endmodule

// ==== dv/spi_slave_model.sv ====
// Behavioural serial slave standing on the master's pins.
// Assumes the bench holds clr high while it changes the clock polarity.
module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       cpha,
  input  wire logic       clr,
  input  wire logic [7:0] resp,
  output logic            miso,
  output logic [7:0]      got
);
  timeunit 1ns;
  timeprecision 1ps;
  int         edges;  // Serial clock edges seen in this frame.
  logic [7:0] sh;     // Bits taken from the master so far.
  logic       out_q;  // Bit presented while selected.
  // A deselected slave lets its line drift, shown as the inverse of the last bit.
  assign miso = sel_n ? ~out_q : out_q;
  initial begin
    edges = 0;
    out_q = 1'b0;
    sh = 8'h00;
    got = 8'h00;
  end
  // Odd edges lead and even edges trail; phase picks the sampling one.
  always @(sck or posedge clr) begin
    if (clr) begin
      edges = 0;
      out_q = resp[7];
    end else if (!sel_n) begin
      edges = edges + 1;
      if ((edges % 2 == 1) != cpha) begin
        sh = {sh[6:0], mosi};  // Both directions run MSB first.
      end else if (edges < 16) begin
        out_q = resp[7 - (cpha ? (edges - 1) / 2 : edges / 2)];
      end
      if (edges == 16) begin
        got = sh;
        edges = 0;
        out_q = resp[7];
      end
    end
  end
endmodule

// ==== dv/spi_master_slave_select_modes_test.sv ====
// Self-checking bench for the master serial port and its select modes.
// Assumes the slave model is compiled before this file.
module spi_master_slave_select_modes_test;
  timeunit 1ns;
  timeprecision 1ps;
  import spi_master_pkg::*;
  logic       sys_clk = 1'b0, rst = 1'b1, clr = 1'b1, pha = 1'b0, ss_in = 1'b1;
  logic       ctrl_wr = 1'b0, cfg_wr = 1'b0, tx_wr = 1'b0, rx_ready = 1'b0, int_enable = 1'b1;
  logic [7:0] ctrl_wdata = 8'h00, cfg_wdata = 8'h00, tx_byte = 8'h00;
  logic [7:0] rate_div = 8'h00, resp = 8'h00, rx_byte, ctrl_rdata, cfg_rdata, got;
  logic       rx_valid, int_request, sck, mosi, miso, ss_o, ss_oe;
  int         n_errors = 0, samples_checked = 0;
  logic [7:0] modes [4] = '{8'h00, 8'h08, 8'h0C, 8'h04};  // Select mode settings.
  logic [1:0] pins  [4] = '{2'b00, 2'b10, 2'b11, 2'b01};  // Expected enable and level.
  always #2.5 sys_clk = ~sys_clk;
  spi_master DUT (.sys_clk(sys_clk), .rst(rst), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata), .rate_div(rate_div), .int_enable(int_enable),
    .tx_wr(tx_wr), .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .rx_byte(rx_byte), .ctrl_rdata(ctrl_rdata), .cfg_rdata(cfg_rdata),
    .int_request(int_request), .sck(sck), .mosi(mosi), .miso(miso),
    .slave_select_line_i(ss_in), .slave_select_line_o(ss_o), .slave_select_line_oe(ss_oe));
  // Only a driven high select line deselects the slave; other modes leave it selected.
  // A single slave stands on the bus, so nothing else can answer on miso.
  spi_slave_model peer (.sck(sck), .mosi(mosi), .sel_n(ss_oe ? ss_o : 1'b0), .cpha(pha),
    .clr(clr), .resp(resp), .miso(miso), .got(got));
  // One-cycle write strobe: 0 control, 1 configuration, 2 transmit byte.
  task automatic put(input int which, input logic [7:0] v);
    @(negedge sys_clk);
    ctrl_wr = (which == 0);
    cfg_wr = (which == 1);
    tx_wr = (which == 2);
    ctrl_wdata = v;
    cfg_wdata = v;
    tx_byte = v;
    @(negedge sys_clk);
    {ctrl_wr, cfg_wr, tx_wr} = 3'b000;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Bounded wait for a status bit; running out counts as a mismatch.
  task automatic wait_bit(input int idx, input logic v);
    int i;
    i = 0;
    while (ctrl_rdata[idx] !== v && i < 600) begin
      @(negedge sys_clk);
      i++;
    end
    chk("status wait", 8'(v), 8'(ctrl_rdata[idx]));
  endtask
  // Takes the head of the receive buffer after checking it.
  task automatic pop(input logic [7:0] exp);
    chk("rx valid", 8'h01, 8'(rx_valid));
    chk("rx byte", exp, rx_byte);
    @(negedge sys_clk);
    rx_ready = 1'b1;
    @(negedge sys_clk);
    rx_ready = 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    fork
      begin
        #(20000 * 5);
        n_errors++;
        wrap_up();
      end
    join_none
    repeat (10) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("ctrl reset", 8'h06, ctrl_rdata);
    chk("cfg reset", 8'h00, cfg_rdata);
    chk("pins reset", 8'h01, {5'h00, sck, ss_oe, ss_o});
    $display("test reset done");
    foreach (modes[i]) begin
      put(0, modes[i]);
      @(negedge sys_clk);
      chk("select pins", 8'(pins[i]), {6'h00, ss_oe, ss_o});
    end
    $display("test select modes done");
    // Every phase and polarity pair, with a slower rate on the last.
    for (int k = 0; k < 4; k++) begin
      clr = 1'b1;
      pha = k[1];
      resp = 8'h3C + 8'(k);
      rate_div = (k == 3) ? 8'h0B : 8'h00;
      put(1, 8'h40 | 8'(k << 4));
      put(0, 8'h09);
      @(negedge sys_clk);
      clr = 1'b0;
      put(2, 8'hA5 ^ 8'(k));
      wait_bit(7, 1'b1);
      chk("slave got", 8'hA5 ^ 8'(k), got);
      chk("ctrl done", 8'h8B, ctrl_rdata);
      chk("irq", 8'h01, 8'(int_request));
      repeat (20) @(negedge sys_clk);
      chk("sck idle", 8'(k[0]), 8'(sck));
      chk("done kept", 8'h8B, ctrl_rdata);
      pop(resp);
    end
    $display("test phase polarity done");
    // The last byte of the loop left the done flag up; clear it first.
    put(0, 8'h09);
    put(2, 8'h11);
    repeat (4) @(negedge sys_clk);
    put(2, 8'h22);
    put(2, 8'h33);
    @(negedge sys_clk);
    chk("collision", 8'h40, ctrl_rdata & 8'h40);
    wait_bit(7, 1'b1);
    chk("first byte", 8'h11, got);
    put(0, 8'h09);
    @(negedge sys_clk);
    wait_bit(7, 1'b1);
    chk("second byte", 8'h22, got);
    put(0, 8'h09);
    put(2, 8'h44);
    repeat (300) @(negedge sys_clk);
    chk("held by full buffer", 8'h22, got);
    pop(resp);
    pop(resp);
    wait_bit(7, 1'b1);
    chk("third byte", 8'h44, got);
    pop(resp);
    $display("test buffering done");
    clr = 1'b1;
    pha = 1'b0;
    put(1, 8'h40);
    put(0, 8'h05);
    clr = 1'b0;
    ss_in = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("fault ctrl", 8'h26, ctrl_rdata);
    chk("fault cfg", 8'h00, cfg_rdata);
    chk("fault irq", 8'h01, 8'(int_request));
    int_enable = 1'b0;
    ss_in = 1'b1;
    put(2, 8'h55);
    repeat (100) @(negedge sys_clk);
    chk("masked irq", 8'h00, 8'(int_request));
    chk("no transfer", 8'h44, got);
    int_enable = 1'b1;
    put(0, 8'h05);
    put(1, 8'h40);
    @(negedge sys_clk);
    wait_bit(7, 1'b1);
    chk("after fault", 8'h55, got);
    pop(resp);
    $display("test mode fault done");
    wrap_up();
  end
endmodule
